// ### banked_data_memory_status_regs.vh
// Offsets, field positions, codes and reset values of the banked data memory
`ifndef BANKED_DATA_MEMORY_STATUS_REGS_VH
`define BANKED_DATA_MEMORY_STATUS_REGS_VH
// Core register offsets, repeated in every bank
`define OFF_INDIRECT_PORT0 7'h00
`define OFF_INDIRECT_PORT1 7'h01
`define OFF_PC_LOW 7'h02
`define OFF_STATUS 7'h03
`define OFF_PTR0_LOW 7'h04
`define OFF_PTR0_HIGH 7'h05
`define OFF_PTR1_LOW 7'h06
`define OFF_PTR1_HIGH 7'h07
`define OFF_BANK_SELECT 7'h08
`define OFF_WORKING 7'h09
`define OFF_PC_LATCH_HIGH 7'h0a
`define OFF_INT_CONTROL 7'h0b
// Region limits inside a bank
`define OFF_SFR_FIRST 7'h0c
`define OFF_SFR_LAST_SMALL 7'h1f
`define OFF_SFR_LAST_BIG 7'h6f
`define OFF_GPR_FIRST 7'h20
`define OFF_COMMON_FIRST 7'h70
`define BANK_FIRST_BIG_SFR 6'h3c
// Linear view of general purpose RAM
`define GPR_TOTAL 13'h12c0
`define LINEAR_TAG 2'h1
`define DIRECT_TAG 2'h0
// Status bit positions
`define ST_TIMEOUT 4
`define ST_POWERDOWN 3
`define ST_ZERO 2
`define ST_NIBBLE 1
`define ST_CARRY 0
// Arithmetic unit operations
`define OP_NONE 3'h0
`define OP_ADD 3'h1
`define OP_SUB 3'h2
`define OP_LOGIC 3'h3
`define OP_ROT_LEFT 3'h4
`define OP_ROT_RIGHT 3'h5
`define OP_CLEAR 3'h6
// Flag masks, bit order {zero, nibble carry, carry}
`define FM_NONE 3'h0
`define FM_ALL 3'h7
`define FM_ZERO 3'h4
`define FM_CARRY 3'h1
`define FM_CARRIES 3'h3
// Decoded regions of one access
`define RG_NONE 3'h0
`define RG_CORE 3'h1
`define RG_SFR 3'h2
`define RG_GPR 3'h3
`define RG_COMMON 3'h4
// Reset values
`define RST_BYTE 8'h00
`define RST_BANK 6'h00
`define RST_ADDR 13'h0000
`define RST_STATUS 8'h18
`endif

// ### banked_data_memory_status.v
// Banked data memory decode, core registers and status flags
`timescale 1ns/100ps
`include "banked_data_memory_status_regs.vh"
// Notes on behaviour
// - Address is bank number plus seven-bit offset
// - Every location reachable directly or via pointers
// - Core registers occupy first twelve offsets everywhere
// - Core registers decoded in their fixed order
// - Flag-updating result overrides status flag writes
// - Timeout and power-down flags ignore software writes
// - Status upper bits zero, fixed flag positions
// - Timeout flag set by clear/sleep, cleared by watchdog
// - Power-down set by clear, cleared by sleep
// - Zero flag follows zero result
// - Nibble carry from bit three on add/subtract
// - Carry from top bit on add/subtract
// - Subtract adds two's complement; carries mean no-borrow
// - Rotate through carry loads shifted-out bit
// - Power-on reset sets timeout/power-down, clears rest
// - Clearing status yields 000u uluu
// - Special registers follow core registers, size by bank
// - Eighty bytes general purpose RAM per bank in banks 0-59, none in banks 60-63
// - Pointers reach general RAM as one linear space
// - Sixteen common bytes shared by all banks
// - Sixty-four banks of 128 bytes each
module banked_data_memory_status (
    input wire clk,
    input wire rstn,
    input wire otherReset,
    input wire otherResetTimeout,
    input wire otherResetPowerDown,
    input wire accValid,
    input wire accWrite,
    input wire [6:0] accOffset,
    input wire [7:0] accWdata,
    input wire aluValid,
    input wire [2:0] aluOp,
    input wire [7:0] aluA,
    input wire [7:0] aluB,
    input wire aluToFile,
    input wire wdtClearCmd,
    input wire sleepCmd,
    input wire wdtTimeout,
    input wire [7:0] sfrRdata,
    output reg [7:0] rdData,
    output reg rdValid,
    output reg [12:0] dataAddr,
    output reg [7:0] aluResult,
    output reg [7:0] status,
    output reg [5:0] bankSelect,
    output reg [7:0] workingRegister,
    output reg [7:0] programCounterLow,
    output reg [7:0] programCounterLatchHigh,
    output reg [7:0] interruptControl,
    output reg sfrValid,
    output reg sfrWrite,
    output reg [12:0] sfrAddr,
    output reg [7:0] sfrWdata
);

////////////////////////////////////////////////////////////////////////////////
// Storage

reg [7:0] pointer0Low;
reg [7:0] pointer0High;
reg [7:0] pointer1Low;
reg [7:0] pointer1High;
// Banks 60-63 hold no general purpose RAM, so RAM is 60 x 80 bytes
reg [7:0] general_purpose_ram [0:4799];
reg [7:0] common [0:15];
reg [2:0] s1Region;
reg s1Read;
reg [7:0] s1Data;
reg [7:0] gprRead;

////////////////////////////////////////////////////////////////////////////////
// Arithmetic unit

reg [7:0] aluRes;
reg [2:0] aluFlags;
reg [2:0] flagMask;
reg [2:0] flagLock;
reg [8:0] sum;
reg [4:0] nib;
reg [7:0] opB;
reg carryIn;

always @*
begin
    opB = aluB;
    carryIn = 1'b0;
    if (aluOp == `OP_SUB)
    begin
        opB = ~aluB;
        carryIn = 1'b1;
    end
    sum = {1'b0, aluA} + {1'b0, opB} + {8'h00, carryIn};
    nib = {1'b0, aluA[3:0]} + {1'b0, opB[3:0]} + {4'h0, carryIn};
    aluRes = sum[7:0];
    aluFlags = {1'b0, nib[4], sum[8]};
    flagMask = `FM_ALL;
    case (aluOp)
        `OP_ADD, `OP_SUB:
        begin
            flagMask = `FM_ALL;
        end
        `OP_LOGIC:
        begin
            aluRes = aluB;
            flagMask = `FM_ZERO;
        end
        `OP_ROT_LEFT:
        begin
            aluRes = {aluA[6:0], status[`ST_CARRY]};
            aluFlags[`ST_CARRY] = aluA[7];
            flagMask = `FM_CARRY;
        end
        `OP_ROT_RIGHT:
        begin
            aluRes = {status[`ST_CARRY], aluA[7:1]};
            aluFlags[`ST_CARRY] = aluA[0];
            flagMask = `FM_CARRY;
        end
        `OP_CLEAR:
        begin
            aluRes = `RST_BYTE;
            flagMask = `FM_ZERO;
        end
        default:
        begin
            flagMask = `FM_NONE;
        end
    endcase
    if (!aluValid)
    begin
        flagMask = `FM_NONE;
    end
    aluFlags[`ST_ZERO] = (aluRes == `RST_BYTE);
    // Any flag-updating op shields all three bits from its own write data
    flagLock = `FM_NONE;
    if (flagMask != `FM_NONE)
    begin
        flagLock = `FM_ALL;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Address formation and decode

wire [7:0] wrData = (aluValid && aluToFile) ? aluRes : accWdata;
wire viaPort = (accOffset == `OFF_INDIRECT_PORT0) ||
    (accOffset == `OFF_INDIRECT_PORT1);
wire [15:0] ptr = (accOffset == `OFF_INDIRECT_PORT0) ?
    {pointer0High, pointer0Low} : {pointer1High, pointer1Low};
reg [12:0] addr;
reg [2:0] region;
reg [12:0] gprIdx;
reg [3:0] comIdx;
reg [6:0] off;
reg [5:0] bank;
reg [6:0] sfrLast;

always @*
begin
    addr = {bankSelect, accOffset};
    region = `RG_NONE;
    gprIdx = `RST_ADDR;
    off = addr[6:0];
    bank = addr[12:7];
    comIdx = off[3:0];
    sfrLast = (bank >= `BANK_FIRST_BIG_SFR) ? `OFF_SFR_LAST_BIG :
        `OFF_SFR_LAST_SMALL;
    if (viaPort)
    begin
        // Program memory reads through pointers are not served here
        addr = ptr[12:0];
        if (ptr[15])
        begin
            region = `RG_NONE;
        end
        else if (ptr[14:13] == `LINEAR_TAG)
        begin
            if (ptr[12:0] < `GPR_TOTAL)
            begin
                region = `RG_GPR;
                gprIdx = ptr[12:0];
            end
        end
        else if (ptr[14:13] == `DIRECT_TAG)
        begin
            off = addr[6:0];
            bank = addr[12:7];
            comIdx = off[3:0];
            sfrLast = (bank >= `BANK_FIRST_BIG_SFR) ? `OFF_SFR_LAST_BIG :
                `OFF_SFR_LAST_SMALL;
            // A pointer aimed at an indirect port reads as zero
            if (off > `OFF_INDIRECT_PORT1)
            begin
                region = `RG_CORE;
            end
        end
    end
    else
    begin
        region = `RG_CORE;
    end
    if (region == `RG_CORE)
    begin
        if (off >= `OFF_COMMON_FIRST)
        begin
            region = `RG_COMMON;
        end
        else if (off >= `OFF_SFR_FIRST && off <= sfrLast)
        begin
            region = `RG_SFR;
        end
        else if (off >= `OFF_GPR_FIRST && bank < `BANK_FIRST_BIG_SFR)
        begin
            region = `RG_GPR;
            gprIdx = {bank, 6'h00} + {2'h0, bank, 4'h0}
                + {6'h00, off} - {6'h00, `OFF_GPR_FIRST};
        end
        else if (off >= `OFF_SFR_FIRST)
        begin
            region = `RG_NONE;
        end
    end
end

wire coreHit = accValid && region == `RG_CORE;
wire coreWr = coreHit && accWrite;

////////////////////////////////////////////////////////////////////////////////
// Core register read mux

reg [7:0] coreRead;

always @*
begin
    case (off)
        `OFF_PC_LOW: coreRead = programCounterLow;
        `OFF_STATUS: coreRead = status;
        `OFF_PTR0_LOW: coreRead = pointer0Low;
        `OFF_PTR0_HIGH: coreRead = pointer0High;
        `OFF_PTR1_LOW: coreRead = pointer1Low;
        `OFF_PTR1_HIGH: coreRead = pointer1High;
        `OFF_BANK_SELECT: coreRead = {2'h0, bankSelect};
        `OFF_WORKING: coreRead = workingRegister;
        `OFF_PC_LATCH_HIGH: coreRead = programCounterLatchHigh;
        `OFF_INT_CONTROL: coreRead = interruptControl;
        default: coreRead = `RST_BYTE;
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// Status register

reg [2:0] next_flags;
reg next_timeout;
reg next_powerDown;
wire statusWr = coreWr && off == `OFF_STATUS;

always @*
begin
    next_flags = status[2:0];
    if (statusWr)
    begin
        next_flags = (wrData[2:0] & ~flagLock) | (status[2:0] & flagLock);
    end
    next_flags = (aluFlags & flagMask) | (next_flags & ~flagMask);
    // Hardware events only; the write data never reaches these bits
    next_timeout = status[`ST_TIMEOUT];
    next_powerDown = status[`ST_POWERDOWN];
    if (wdtClearCmd)
    begin
        next_timeout = 1'b1;
        next_powerDown = 1'b1;
    end
    else if (sleepCmd)
    begin
        next_timeout = 1'b1;
        next_powerDown = 1'b0;
    end
    // A time-out outranks a clear issued in the same cycle
    if (wdtTimeout)
    begin
        next_timeout = 1'b0;
    end
    if (otherReset)
    begin
        next_timeout = otherResetTimeout;
        next_powerDown = otherResetPowerDown;
    end
end

always @(posedge clk or negedge rstn)
begin
    if (!rstn)
    begin
        status <= `RST_STATUS;
    end
    else
    begin
        status <= {3'h0, next_timeout, next_powerDown, next_flags};
    end
end

////////////////////////////////////////////////////////////////////////////////
// Other core registers

always @(posedge clk or negedge rstn)
begin
    if (!rstn)
    begin
        programCounterLow <= `RST_BYTE;
        pointer0Low <= `RST_BYTE;
        pointer0High <= `RST_BYTE;
        pointer1Low <= `RST_BYTE;
        pointer1High <= `RST_BYTE;
        bankSelect <= `RST_BANK;
        workingRegister <= `RST_BYTE;
        programCounterLatchHigh <= `RST_BYTE;
        interruptControl <= `RST_BYTE;
        aluResult <= `RST_BYTE;
    end
    else
    begin
        if (aluValid)
        begin
            aluResult <= aluRes;
        end
        if (coreWr)
        begin
            case (off)
                `OFF_PC_LOW: programCounterLow <= wrData;
                `OFF_PTR0_LOW: pointer0Low <= wrData;
                `OFF_PTR0_HIGH: pointer0High <= wrData;
                `OFF_PTR1_LOW: pointer1Low <= wrData;
                `OFF_PTR1_HIGH: pointer1High <= wrData;
                `OFF_BANK_SELECT: bankSelect <= wrData[5:0];
                `OFF_WORKING: workingRegister <= wrData;
                `OFF_PC_LATCH_HIGH: programCounterLatchHigh <= wrData;
                `OFF_INT_CONTROL: interruptControl <= wrData;
                default: programCounterLow <= programCounterLow;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// RAM arrays, no reset so they map onto block memory

always @(posedge clk)
begin
    if (accValid && accWrite && region == `RG_GPR)
    begin
        general_purpose_ram[gprIdx] <= wrData;
    end
    if (accValid && accWrite && region == `RG_COMMON)
    begin
        common[comIdx] <= wrData;
    end
    gprRead <= general_purpose_ram[gprIdx];
end

////////////////////////////////////////////////////////////////////////////////
// Two-stage read pipeline and peripheral strobe

always @(posedge clk or negedge rstn)
begin
    if (!rstn)
    begin
        s1Region <= `RG_NONE;
        s1Read <= 1'b0;
        s1Data <= `RST_BYTE;
        dataAddr <= `RST_ADDR;
        sfrValid <= 1'b0;
        sfrWrite <= 1'b0;
        sfrAddr <= `RST_ADDR;
        sfrWdata <= `RST_BYTE;
        rdData <= `RST_BYTE;
        rdValid <= 1'b0;
    end
    else
    begin
        s1Read <= accValid && !accWrite;
        s1Region <= region;
        s1Data <= `RST_BYTE;
        if (region == `RG_CORE)
        begin
            s1Data <= coreRead;
        end
        else if (region == `RG_COMMON)
        begin
            s1Data <= common[comIdx];
        end
        if (accValid)
        begin
            dataAddr <= addr;
        end
        sfrValid <= accValid && region == `RG_SFR;
        sfrWrite <= accValid && accWrite && region == `RG_SFR;
        if (accValid && region == `RG_SFR)
        begin
            sfrAddr <= addr;
            sfrWdata <= wrData;
        end
        rdValid <= s1Read;
        if (s1Read)
        begin
            case (s1Region)
                `RG_GPR: rdData <= gprRead;
                `RG_SFR: rdData <= sfrRdata;
                `RG_CORE, `RG_COMMON: rdData <= s1Data;
                default: rdData <= `RST_BYTE;
            endcase
        end
    end
end

endmodule

// ### banked_data_memory_status_monitor.sv
// Checker for the banked data memory and status flag ports
`timescale 1ns/100ps
`include "banked_data_memory_status_regs.vh"
module banked_data_memory_status_monitor (
    input wire clk,
    input wire rstn,
    input wire otherReset,
    input wire accValid,
    input wire accWrite,
    input wire [6:0] accOffset,
    input wire aluValid,
    input wire [2:0] aluOp,
    input wire [7:0] aluB,
    input wire wdtClearCmd,
    input wire sleepCmd,
    input wire wdtTimeout,
    input wire rdValid,
    input wire [12:0] dataAddr,
    input wire [7:0] status,
    input wire [5:0] bankSelect,
    input wire sfrValid,
    input wire [12:0] sfrAddr
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // No flag event competes with a plain status write
    wire quiet = !otherReset && !wdtTimeout && !wdtClearCmd && !sleepCmd;
    ////////////////////////////////////////////////////////////////////////
    sequence rdReq;
        accValid && !accWrite;
    endsequence
    rd_answer_time_a: assert property (rdReq |-> ##2 rdValid)
        else $error("read answer missing two cycles after request");
    rd_no_spurious_a: assert property (rdValid |-> $past(accValid && !accWrite, 2))
        else $error("read answer without a request");
    status_top_zero_a: assert property (status[7:5] == 3'h0)
        else $error("status upper bits not zero");
    timeout_clear_a: assert property (wdtTimeout && !otherReset |=> !status[4])
        else $error("timeout flag not cleared by watchdog event");
    watch_clear_a: assert property (wdtClearCmd && !wdtTimeout && !otherReset
        |=> status[4:3] == 2'b11)
        else $error("watchdog clear did not set both flags");
    sleep_flags_a: assert property (sleepCmd && !otherReset && !wdtTimeout && !wdtClearCmd
        |=> status[4:3] == 2'b10)
        else $error("sleep did not give timeout set, power-down clear");
    locked_flags_a: assert property (accValid && accWrite && accOffset == `OFF_STATUS
        && quiet |=> $stable(status[4:3]))
        else $error("software write changed a locked flag");
    sfr_strobe_a: assert property (accValid && accOffset >= 7'h0c && accOffset <= 7'h1f
        |=> sfrValid && sfrAddr == {$past(bankSelect), $past(accOffset)})
        else $error("special register strobe or address wrong");
    direct_addr_a: assert property (accValid && accOffset > 7'h01
        |=> dataAddr == {$past(bankSelect), $past(accOffset)})
        else $error("direct address not bank and offset");
    zero_logic_a: assert property (aluValid && aluOp == `OP_LOGIC
        |=> status[2] == ($past(aluB) == 8'h00))
        else $error("zero flag does not follow logic result");
endmodule
bind banked_data_memory_status banked_data_memory_status_monitor i_monitor (
    .clk, .rstn, .otherReset, .accValid, .accWrite, .accOffset, .aluValid, .aluOp, .aluB,
    .wdtClearCmd, .sleepCmd, .wdtTimeout, .rdValid, .dataAddr, .status, .bankSelect,
    .sfrValid, .sfrAddr
);

// ### sfr_responder.sv
// Peripheral side answering special function register reads
`timescale 1ns/100ps
module sfr_responder (
    input wire clk,
    input wire sfrValid,
    input wire sfrWrite,
    input wire [12:0] sfrAddr,
    output logic [7:0] sfrRdata
);
    initial sfrRdata = 8'h00;
    // Stale data is scrambled so a late sample cannot pass by luck
    always @(posedge clk)
    begin
        #1;
        if (sfrValid && !sfrWrite)
            sfrRdata = sfrAddr[7:0] ^ 8'h5a;
        else
            sfrRdata = ~sfrRdata;
    end
endmodule

// ### testbench.sv
// Directed bench for banked data memory decode and status flags
`timescale 1ns/100ps
`include "banked_data_memory_status_regs.vh"
module testbench;
    reg clk, rstn, otherReset, otherResetTimeout, otherResetPowerDown;
    reg accValid, accWrite, aluValid, aluToFile, wdtClearCmd, sleepCmd, wdtTimeout;
    reg [6:0] accOffset;
    reg [7:0] accWdata, aluA, aluB;
    reg [2:0] aluOp, fl;
    wire [7:0] sfrRdata, rdData, aluResult, status, workingRegister, programCounterLow;
    wire [7:0] programCounterLatchHigh, interruptControl, sfrWdata;
    wire rdValid, sfrValid, sfrWrite;
    wire [12:0] dataAddr, sfrAddr;
    wire [5:0] bankSelect;
    integer error_cnt, tests_run, i;
    banked_data_memory_status i_banked_data_memory_status (.clk, .rstn, .otherReset,
        .otherResetTimeout, .otherResetPowerDown, .accValid, .accWrite, .accOffset,
        .accWdata, .aluValid, .aluOp, .aluA, .aluB, .aluToFile, .wdtClearCmd, .sleepCmd,
        .wdtTimeout, .sfrRdata, .rdData, .rdValid, .dataAddr, .aluResult, .status,
        .bankSelect, .workingRegister, .programCounterLow, .programCounterLatchHigh,
        .interruptControl, .sfrValid, .sfrWrite, .sfrAddr, .sfrWdata);
    sfr_responder i_sfr_responder (.clk, .sfrValid, .sfrWrite, .sfrAddr, .sfrRdata);
    ////////////////////////////////////////////////////////////////////////
    task chk(input [12:0] seen, input [12:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp)
            begin
                error_cnt = error_cnt + 1;
                $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // Control bits: reset, timeout, sleep, clear, alu, write, valid
    task go(input [6:0] c, input [6:0] off, input [7:0] d);
        begin
            {otherReset, wdtTimeout, sleepCmd, wdtClearCmd, aluValid, accWrite, accValid} = c;
            accOffset = off;
            accWdata = d;
            @(posedge clk) #1;
        end
    endtask
    task wr(input [6:0] off, input [7:0] d);
        go(7'h03, off, d);
    endtask
    task rd(input [6:0] off, input [7:0] exp);
        begin
            go(7'h01, off, 8'h00);
            go(7'h00, 7'h00, 8'h00);
            chk(rdValid, 1'b1);
            chk(rdData, exp);
        end
    endtask
    // Flag model kept here, independent of the design
    task aluChk(input [2:0] op, input [7:0] a, input [7:0] b);
        reg [8:0] s;
        reg [4:0] n;
        reg [7:0] bb;
        begin
            bb = (op == `OP_SUB) ? ~b : b;
            n = a[3:0] + bb[3:0] + (op == `OP_SUB);
            case (op)
                `OP_ROT_LEFT: s = {a, fl[0]};
                `OP_ROT_RIGHT: s = {a[0], fl[0], a[7:1]};
                `OP_LOGIC: s = {1'b0, b};
                default: s = a + bb + (op == `OP_SUB);
            endcase
            if (op == `OP_ADD || op == `OP_SUB)
                fl = {s[7:0] == 8'h00, n[4], s[8]};
            else if (op == `OP_LOGIC)
                fl[2] = (b == 8'h00);
            else
                fl[0] = s[8];
            aluOp = op;
            aluA = a;
            aluB = b;
            go(7'h04, 7'h00, 8'h00);
            chk(aluResult, s[7:0]);
            chk(status[2:0], fl);
        end
    endtask
    task close_out;
        begin
            if (error_cnt == 0 && tests_run > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    initial
    begin
        #100000;
        error_cnt = error_cnt + 1;
        $display("[ERR] %0t watchdog expired", $time);
        close_out;
    end
    initial
    begin
        error_cnt = 0;
        tests_run = 0;
        {otherReset, wdtTimeout, sleepCmd, wdtClearCmd, aluValid, accWrite, accValid} = 7'h00;
        {otherResetTimeout, otherResetPowerDown, aluToFile, accOffset} = 10'h000;
        {accWdata, aluA, aluB, aluOp, fl} = 30'h0;
        rstn = 0;
        repeat (20) @(posedge clk);
        #1 rstn = 1;
        chk(status, 8'h18);
        rd(`OFF_STATUS, 8'h18);
        wr(`OFF_BANK_SELECT, 8'h05);
        wr(7'h20, 8'ha5);
        chk(dataAddr, {6'h05, 7'h20});
        wr(7'h75, 8'h3c);
        wr(`OFF_BANK_SELECT, 8'h3e);
        rd(7'h75, 8'h3c);
        rd(`OFF_BANK_SELECT, 8'h3e);
        wr(`OFF_BANK_SELECT, 8'h05);
        rd(7'h20, 8'ha5);
        wr(`OFF_BANK_SELECT, 8'h3c);
        rd(7'h50, 8'h50 ^ 8'h5a);
        wr(`OFF_BANK_SELECT, 8'h00);
        rd(7'h0c, 8'h0c ^ 8'h5a);
        wr(7'h0d, 8'h66);
        chk(sfrWrite, 1'b1);
        chk(sfrWdata, 8'h66);
        chk(sfrAddr, {6'h00, 7'h0d});
        wr(`OFF_BANK_SELECT, 8'h07);
        for (i = 2; i < 12; i = i + 1)
            if (i != 3 && i != 8)
                wr(i[6:0], 8'h40 + i[7:0]);
        wr(`OFF_BANK_SELECT, 8'h21);
        for (i = 2; i < 12; i = i + 1)
            if (i != 3 && i != 8)
                rd(i[6:0], 8'h40 + i[7:0]);
        chk(workingRegister, 8'h49);
        chk(interruptControl, 8'h4b);
        chk(programCounterLow, 8'h42);
        chk(programCounterLatchHigh, 8'h4a);
        wr(`OFF_PTR0_LOW, 8'h50);
        wr(`OFF_PTR0_HIGH, 8'h20);
        wr(`OFF_INDIRECT_PORT0, 8'h77);
        wr(`OFF_BANK_SELECT, 8'h01);
        rd(7'h20, 8'h77);
        wr(`OFF_PTR1_LOW, 8'h30);
        wr(`OFF_PTR1_HIGH, 8'h01);
        wr(`OFF_BANK_SELECT, 8'h02);
        wr(7'h30, 8'h99);
        rd(`OFF_INDIRECT_PORT1, 8'h99);
        wr(`OFF_PTR0_HIGH, 8'h80);
        rd(`OFF_INDIRECT_PORT0, 8'h00);
        wr(`OFF_PTR0_LOW, 8'hc0);
        wr(`OFF_PTR0_HIGH, 8'h32);
        rd(`OFF_INDIRECT_PORT0, 8'h00);
        wr(`OFF_STATUS, 8'hff);
        chk(status, 8'h1f);
        wr(`OFF_STATUS, 8'h00);
        chk(status, 8'h18);
        go(7'h10, 7'h00, 8'h00);
        chk(status, 8'h10);
        go(7'h20, 7'h00, 8'h00);
        chk(status, 8'h00);
        wr(`OFF_STATUS, 8'hff);
        chk(status, 8'h07);
        wr(`OFF_STATUS, 8'h00);
        go(7'h08, 7'h00, 8'h00);
        chk(status, 8'h18);
        aluOp = `OP_CLEAR;
        aluToFile = 1;
        go(7'h07, `OFF_STATUS, 8'h00);
        chk(status, 8'h1c);
        wr(`OFF_STATUS, 8'h03);
        go(7'h07, `OFF_STATUS, 8'h00);
        chk(status, 8'h1f);
        aluOp = `OP_ADD;
        aluA = 8'h01;
        aluB = 8'h01;
        go(7'h07, `OFF_STATUS, 8'hff);
        chk(status, 8'h18);
        aluOp = `OP_LOGIC;
        aluB = 8'h03;
        go(7'h07, `OFF_STATUS, 8'hff);
        chk(status, 8'h18);
        aluToFile = 0;
        fl = 3'h0;
        aluChk(`OP_ADD, 8'h0f, 8'h01);
        aluChk(`OP_ADD, 8'hff, 8'h01);
        aluChk(`OP_SUB, 8'h05, 8'h05);
        aluChk(`OP_SUB, 8'h03, 8'h05);
        aluChk(`OP_LOGIC, 8'h00, 8'h00);
        aluChk(`OP_ROT_LEFT, 8'h81, 8'h00);
        aluChk(`OP_ROT_RIGHT, 8'h02, 8'h00);
        aluChk(`OP_LOGIC, 8'h00, 8'h5a);
        otherResetPowerDown = 1;
        go(7'h40, 7'h00, 8'h00);
        chk(status, {3'h0, 2'b01, fl});
        rstn = 0;
        #10;
        chk(status, 8'h18);
        @(posedge clk) #1;
        rstn = 1;
        rd(`OFF_STATUS, 8'h18);
        close_out;
    end
endmodule
